/* clock_gate_defines.vh */
// Offsets, field positions and reset values of the clock gating block
`ifndef CLOCK_GATE_DEFINES_VH
`define CLOCK_GATE_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RUN_CLOCK_CONFIG_OFS     12'h060
`define RUN_GATE_REG1_OFS        12'h104
`define SLEEP_GATE_REG1_OFS      12'h114
`define DEEP_SLEEP_GATE_REG1_OFS 12'h124
`define FAULT_STATUS_OFS         12'h130
`define FAULT_MASK_OFS           12'h134
`define REG_ADDR_W               12

// ----------------------------------------------------------------
// Gating field positions
// ----------------------------------------------------------------
`define GP_COUNTER3_GATE_BIT       19
`define GP_COUNTER2_GATE_BIT       18
`define GP_COUNTER1_GATE_BIT       17
`define GP_COUNTER0_GATE_BIT       16
`define TWO_WIRE_UNIT1_GATE_BIT    14
`define TWO_WIRE_UNIT0_GATE_BIT    12
`define SYNC_SERIAL_UNIT1_GATE_BIT 5
`define SYNC_SERIAL_UNIT0_GATE_BIT 4
`define ASYNC_SERIAL_UNIT2_GATE_BIT 2
`define ASYNC_SERIAL_UNIT1_GATE_BIT 1
`define ASYNC_SERIAL_UNIT0_GATE_BIT 0

// Writable bits of the gating registers; all others read zero
`define GATE_WRITE_MASK 32'h000F5037
`define GATE_RESET      32'h00000000

// Auto-gating select position in the run clock configuration
`define AUTO_GATE_SELECT_BIT 0
`define RUN_CLOCK_CONFIG_MASK 32'h00000001
`define RUN_CLOCK_CONFIG_RESET 32'h00000000

// Number of gated peripherals
`define NUM_PERIPH 11

`endif

/* gate_select.v */
// Per-peripheral clock enable selection from the power mode
`timescale 1ns/1ps
`default_nettype none

module gate_select #(
	parameter NUM = 11
) (
	input  wire           clk,
	input  wire           rst_n,
	input  wire [NUM-1:0] run_gate,
	input  wire [NUM-1:0] sleep_gate,
	input  wire [NUM-1:0] deep_gate,
	input  wire           auto_gate,
	input  wire           sleep_mode,
	input  wire           deep_sleep_mode,
	output wire [NUM-1:0] clk_en
);

	// ----------------------------------------------------------------
	// One registered enable per peripheral
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM; i = i + 1) begin : g_sel
			reg  en;
			wire next_en;
			// Deep sleep wins over sleep; run register without auto gating
			assign next_en = !auto_gate      ? run_gate[i] :
			                 deep_sleep_mode ? deep_gate[i] :
			                 sleep_mode      ? sleep_gate[i] : run_gate[i];
			// Flop output keeps the enable free of glitches
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					en <= 1'b0;
				end else begin
					en <= next_en;
				end
			end
			assign clk_en[i] = en;
		end
	endgenerate

endmodule
`default_nettype wire

/* fault_detect.v */
// Flags accesses to peripherals whose clock is withheld
`timescale 1ns/1ps
`default_nettype none

module fault_detect #(
	parameter NUM = 11
) (
	input  wire           clk,
	input  wire           rst_n,
	input  wire [NUM-1:0] access,
	input  wire [NUM-1:0] clk_en,
	output reg  [NUM-1:0] fault
);

	// ----------------------------------------------------------------
	// One-cycle fault pulse per denied access
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault <= {NUM{1'b0}};
		end else begin
			fault <= access & ~clk_en;
		end
	end

endmodule
`default_nettype wire

/* deep_sleep_clock_gate_ctrl.v */
// Clock gating control with AHB-Lite registers and bus fault reporting
// What this block does
// - Set gating bit delivers clock to peripheral
// - Cleared bit: unclocked, accesses give bus fault
// - All gating bits reset to zero
// - Separate run, sleep and deep-sleep registers
// - Sleep registers apply only with auto gating
// - Bits 19 to 16 gate counters 3..0
// - Bits 14, 12 gate two-wire units 1, 0
// - Bits 5, 4 gate sync serial 1, 0
// - Bits 2..0 gate async serial 2..0
// - Reserved bits read-only, return zero
// - Deep-sleep register at offset 0x124, 32 bits
`timescale 1ns/1ps
`default_nettype none
`include "clock_gate_defines.vh"

module deep_sleep_clock_gate_ctrl #(
	parameter NUM = `NUM_PERIPH
) (
	input  wire           sys_clk,
	input  wire           resetn,
	input  wire           hsel,
	input  wire [31:0]    haddr,
	input  wire [1:0]     htrans,
	input  wire           hwrite,
	input  wire [2:0]     hsize,
	input  wire [31:0]    hwdata,
	input  wire           hready,
	output reg  [31:0]    hrdata,
	output reg            hreadyout,
	output reg            hresp,
	input  wire           sleep_mode,
	input  wire           deep_sleep_mode,
	input  wire [NUM-1:0] periph_access,
	output wire [NUM-1:0] periph_clk_en,
	output reg  [NUM-1:0] periph_bus_fault,
	output reg            irq
);

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	reg rst_meta;
	reg rst_n;
	// Release through two flops
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [31:0] run_clock_config;
	reg  [31:0] run_gate_reg1;
	reg  [31:0] sleep_gate_reg1;
	reg  [31:0] deep_sleep_gate_reg1;
	reg  [31:0] fault_status;
	reg  [31:0] fault_mask;

	// Data phase capture
	reg                   dp_write;
	reg                   dp_read;
	reg [`REG_ADDR_W-1:0] dp_addr;

	wire addr_phase;
	wire [NUM-1:0] fault_evt;
	wire [31:0]    fault_set;

	// Valid transfer seen in address phase
	assign addr_phase = hsel & htrans[1] & hready;

	// ----------------------------------------------------------------
	// Compress a 32-bit gating layout to the peripheral vector
	// ----------------------------------------------------------------
	function [NUM-1:0] compress;
		input [31:0] r;
		begin
			compress = {r[`GP_COUNTER3_GATE_BIT],
			            r[`GP_COUNTER2_GATE_BIT],
			            r[`GP_COUNTER1_GATE_BIT],
			            r[`GP_COUNTER0_GATE_BIT],
			            r[`TWO_WIRE_UNIT1_GATE_BIT],
			            r[`TWO_WIRE_UNIT0_GATE_BIT],
			            r[`SYNC_SERIAL_UNIT1_GATE_BIT],
			            r[`SYNC_SERIAL_UNIT0_GATE_BIT],
			            r[`ASYNC_SERIAL_UNIT2_GATE_BIT],
			            r[`ASYNC_SERIAL_UNIT1_GATE_BIT],
			            r[`ASYNC_SERIAL_UNIT0_GATE_BIT]};
		end
	endfunction

	// Expand the peripheral vector back to the register layout
	function [31:0] expand;
		input [NUM-1:0] v;
		begin
			expand = 32'h00000000;
			expand[`GP_COUNTER3_GATE_BIT]        = v[10];
			expand[`GP_COUNTER2_GATE_BIT]        = v[9];
			expand[`GP_COUNTER1_GATE_BIT]        = v[8];
			expand[`GP_COUNTER0_GATE_BIT]        = v[7];
			expand[`TWO_WIRE_UNIT1_GATE_BIT]     = v[6];
			expand[`TWO_WIRE_UNIT0_GATE_BIT]     = v[5];
			expand[`SYNC_SERIAL_UNIT1_GATE_BIT]  = v[4];
			expand[`SYNC_SERIAL_UNIT0_GATE_BIT]  = v[3];
			expand[`ASYNC_SERIAL_UNIT2_GATE_BIT] = v[2];
			expand[`ASYNC_SERIAL_UNIT1_GATE_BIT] = v[1];
			expand[`ASYNC_SERIAL_UNIT0_GATE_BIT] = v[0];
		end
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite transfer tracking
	// ----------------------------------------------------------------
	// Writes take no wait; reads insert one wait state
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_write  <= 1'b0;
			dp_read   <= 1'b0;
			dp_addr   <= {`REG_ADDR_W{1'b0}};
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;                                  // Always OKAY
			if (addr_phase) begin
				dp_write  <= hwrite;
				dp_read   <= ~hwrite;
				dp_addr   <= haddr[`REG_ADDR_W-1:0];
				hreadyout <= hwrite;
			end else begin
				dp_write  <= 1'b0;
				dp_read   <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Only writable bits store; reserved bits stay zero
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_clock_config     <= `RUN_CLOCK_CONFIG_RESET;
			run_gate_reg1        <= `GATE_RESET;
			sleep_gate_reg1      <= `GATE_RESET;
			deep_sleep_gate_reg1 <= `GATE_RESET;
			fault_mask           <= 32'h00000000;
		end else if (dp_write) begin
			case (dp_addr)
				`RUN_CLOCK_CONFIG_OFS: begin
					run_clock_config <= hwdata & `RUN_CLOCK_CONFIG_MASK;
				end
				`RUN_GATE_REG1_OFS: begin
					run_gate_reg1 <= hwdata & `GATE_WRITE_MASK;
				end
				`SLEEP_GATE_REG1_OFS: begin
					sleep_gate_reg1 <= hwdata & `GATE_WRITE_MASK;
				end
				`DEEP_SLEEP_GATE_REG1_OFS: begin
					deep_sleep_gate_reg1 <= hwdata & `GATE_WRITE_MASK;
				end
				`FAULT_MASK_OFS: begin
					fault_mask <= hwdata & `GATE_WRITE_MASK;
				end
				default: begin
					fault_mask <= fault_mask;               // Unmapped write ignored
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sticky fault status, write one to clear, set wins
	// ----------------------------------------------------------------
	assign fault_set = expand(fault_evt);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_status <= 32'h00000000;
		end else if (dp_write && dp_addr == `FAULT_STATUS_OFS) begin
			fault_status <= (fault_status & ~hwdata) | fault_set;
		end else begin
			fault_status <= fault_status | fault_set;
		end
	end

	// ----------------------------------------------------------------
	// Read data, taken in the wait state after writes settle
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (dp_read) begin
			case (dp_addr)
				`RUN_CLOCK_CONFIG_OFS:     hrdata <= run_clock_config;
				`RUN_GATE_REG1_OFS:        hrdata <= run_gate_reg1;
				`SLEEP_GATE_REG1_OFS:      hrdata <= sleep_gate_reg1;
				`DEEP_SLEEP_GATE_REG1_OFS: hrdata <= deep_sleep_gate_reg1;
				`FAULT_STATUS_OFS:         hrdata <= fault_status;
				`FAULT_MASK_OFS:           hrdata <= fault_mask;
				default:                   hrdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and fault outputs
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq              <= 1'b0;
			periph_bus_fault <= {NUM{1'b0}};
		end else begin
			irq              <= |(fault_status & fault_mask);
			periph_bus_fault <= fault_evt;
		end
	end

	// ----------------------------------------------------------------
	// Enable selection and fault detection
	// ----------------------------------------------------------------
	gate_select #(
		.NUM (NUM)
	) u_gate_select (
		.clk             (sys_clk),
		.rst_n           (rst_n),
		.run_gate        (compress(run_gate_reg1)),
		.sleep_gate      (compress(sleep_gate_reg1)),
		.deep_gate       (compress(deep_sleep_gate_reg1)),
		.auto_gate       (run_clock_config[`AUTO_GATE_SELECT_BIT]),
		.sleep_mode      (sleep_mode),
		.deep_sleep_mode (deep_sleep_mode),
		.clk_en          (periph_clk_en)
	);

	fault_detect #(
		.NUM (NUM)
	) u_fault_detect (
		.clk    (sys_clk),
		.rst_n  (rst_n),
		.access (periph_access),
		.clk_en (periph_clk_en),
		.fault  (fault_evt)
	);

endmodule
`default_nettype wire

/* deep_sleep_clock_gate_ctrl_props.sv */
// Bus, gating and fault checks for the clock gating block
`timescale 1ns/1ps
`default_nettype none
module gate_ctrl_props #(
	parameter NUM = 11
) (
	input wire logic           sys_clk,
	input wire logic           resetn,
	input wire logic           hsel,
	input wire logic [31:0]    haddr,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic [2:0]     hsize,
	input wire logic [31:0]    hwdata,
	input wire logic           hready,
	input wire logic [31:0]    hrdata,
	input wire logic           hreadyout,
	input wire logic           hresp,
	input wire logic           sleep_mode,
	input wire logic           deep_sleep_mode,
	input wire logic [NUM-1:0] periph_access,
	input wire logic [NUM-1:0] periph_clk_en,
	input wire logic [NUM-1:0] periph_bus_fault,
	input wire logic           irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [NUM-1:0] blk;
	logic [2:0]     ph, wq, mq;
	logic [1:0]     md;
	logic [31:0]    sh;
	logic           tk;
	assign tk = hsel & htrans[1] & hready;
	assign blk = periph_access & ~periph_clk_en;
	// Data phase, deep-sleep shadow, recent causes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ph <= 3'h0;
			wq <= 3'h0;
			mq <= 3'h0;
			md <= 2'h0;
			sh <= 32'h0;
		end else begin
			ph <= tk ? {1'b1, hwrite, haddr[11:0] == 12'h124} : (hreadyout ? 3'h0 : ph);
			wq <= {wq[1:0], tk & hwrite};
			mq <= {mq[1:0], {sleep_mode, deep_sleep_mode} != md};
			md <= {sleep_mode, deep_sleep_mode};
			if (ph == 3'b111 && hreadyout)
				sh <= hwdata & 32'h000F5037;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("slave response not okay");
	read_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (tk && hwrite |=> hreadyout)
		else $error("write stalled");
	rsvd_zero_a: assert property ($rose(hreadyout) |-> (hrdata & ~32'h000F5037) == 32'h0)
		else $error("reserved bits read nonzero");
	deep_readback_a: assert property (ph == 3'b101 && hreadyout |-> hrdata == sh)
		else $error("deep-sleep register readback wrong");
	fault_exact_a: assert property (periph_bus_fault == $past(blk, 2))
		else $error("bus fault does not match gated access");
	reset_quiet_a: assert property (disable iff (1'b0) !resetn ##1 !resetn |-> periph_clk_en == '0 && !irq)
		else $error("outputs active in reset");
	en_cause_a: assert property (!$stable(periph_clk_en) |-> (wq | mq) != 3'h0)
		else $error("clock enable changed without cause");
	cover property (periph_bus_fault != '0);
	cover property ($rose(irq));
	cover property (ph == 3'b101 && hreadyout);
endmodule
bind deep_sleep_clock_gate_ctrl gate_ctrl_props #(.NUM(NUM)) i_gate_ctrl_props (
	.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
	.periph_access(periph_access), .periph_clk_en(periph_clk_en),
	.periph_bus_fault(periph_bus_fault), .irq(irq));
`default_nettype wire

/* periph_model.sv */
// Gated peripherals issuing bus accesses to their units
`timescale 1ns/1ps
`default_nettype none
module periph_model (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        go,
	input wire logic [10:0] sel,
	output logic [10:0]     periph_access
);
	// One-cycle access pulses, also toward unclocked units
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			periph_access <= 11'h0;
		else
			periph_access <= go ? sel : 11'h0;
	end
endmodule
`default_nettype wire

/* test_deep_sleep_clock_gate_ctrl.sv */
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none
module test_deep_sleep_clock_gate_ctrl;
	localparam logic [31:0] MSK = 32'h000F5037;
	logic        sys_clk, resetn, hsel, hwrite, hreadyout, hresp, irq, rd_ph, go, sleep_mode, deep_sleep_mode;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, a, b, c;
	logic [10:0] periph_access, periph_clk_en, periph_bus_fault, sel;
	logic [11:0] ofs [7] = '{12'h060, 12'h104, 12'h114, 12'h124, 12'h130, 12'h134, 12'h200};
	logic [31:0] rq [$];
	logic [10:0] fq [$];
	int          err_total, checks, i;
	deep_sleep_clock_gate_ctrl i_deep_sleep_clock_gate_ctrl (
		.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
		.periph_access(periph_access), .periph_clk_en(periph_clk_en),
		.periph_bus_fault(periph_bus_fault), .irq(irq));
	periph_model i_periph_model (.sys_clk(sys_clk), .resetn(resetn), .go(go), .sel(sel),
		.periph_access(periph_access));
	// ----------------------------------------
	// Helpers and bus tasks
	// ----------------------------------------
	function automatic logic [10:0] pack(input logic [31:0] r);
		return {r[19:16], r[14], r[12], r[5:4], r[2:0]};
	endfunction
	function automatic logic [31:0] spread(input logic [10:0] v);
		return {12'h0, v[10:7], 1'b0, v[6], 1'b0, v[5], 6'h0, v[4:3], 1'b0, v[2:0]};
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One compare per kind of result
	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
		cmp(g, e);
	endtask
	task automatic cmp_flt(input logic [10:0] g, input logic [10:0] e);
		cmp({21'h0, g}, {21'h0, e});
	endtask
	task automatic cmp_en(input logic [10:0] g, input logic [10:0] e);
		cmp({21'h0, g}, {21'h0, e});
	endtask
	task automatic cmp_irq(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask
	task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h0, ad};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= w ? d : ~hwdata;
		rd_ph <= !w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic mode(input logic s, input logic d, input logic [10:0] e);
		sleep_mode <= s;
		deep_sleep_mode <= d;
		repeat (3) @(posedge sys_clk);
		cmp_en(periph_clk_en, e);
	endtask
	task automatic poke(input logic [10:0] e);
		fq.push_back(e);
		sel <= 11'h7FF;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Result watcher: oldest note against each read or fault, idle in reset
	always @(posedge sys_clk) begin
		if (resetn && rd_ph && hreadyout)
			cmp_rd(hrdata, rq.size() ? rq.pop_front() : 32'hDEADBEEF);
		if (resetn && periph_bus_fault !== 11'h0)
			cmp_flt(periph_bus_fault, fq.size() ? fq.pop_front() : 11'h0);
	end
	// ----------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#2000000;
		err_total++;
		complete_run();
	end
	initial begin
		{resetn, hsel, hwrite, rd_ph, go, sleep_mode, deep_sleep_mode} = 7'h0;
		{htrans, haddr, hwdata, sel, err_total, checks} = '0;
		hsize = 3'b010;
		i = $urandom(32'hD2AB);
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		foreach (ofs[j]) rd(ofs[j], 32'h0);
		bus(1'b1, 12'h200, 32'hFFFFFFFF);
		rd(12'h200, 32'h0);
		bus(1'b1, 12'h124, 32'hFFFFFFFF);
		rd(12'h124, MSK);
		$display("test reset and reserved done");
		for (i = 0; i < 11; i++) begin
			bus(1'b1, 12'h104, spread(11'h1 << i));
			rd(12'h104, spread(11'h1 << i));
			mode(1'b0, 1'b0, 11'h1 << i);
		end
		$display("test bit map done");
		a = $urandom() & ~32'h1;
		b = $urandom();
		c = $urandom();
		bus(1'b1, 12'h124, c);
		rd(12'h124, c & MSK);
		c = (c & MSK) | 32'h1;
		bus(1'b1, 12'h124, c);
		rd(12'h124, c);
		bus(1'b1, 12'h104, a);
		bus(1'b1, 12'h114, b);
		mode(1'b0, 1'b1, pack(a));
		mode(1'b1, 1'b0, pack(a));
		bus(1'b1, 12'h060, 32'h1);
		rd(12'h060, 32'h1);
		mode(1'b1, 1'b1, pack(c));
		mode(1'b1, 1'b0, pack(b));
		mode(1'b0, 1'b0, pack(a));
		$display("test mode select done");
		bus(1'b1, 12'h134, MSK);
		poke(~pack(a));
		cmp_irq(irq, 1'b1);
		rd(12'h130, spread(~pack(a)));
		bus(1'b1, 12'h130, MSK);
		rd(12'h130, 32'h0);
		cmp_irq(irq, 1'b0);
		bus(1'b1, 12'h134, 32'h0);
		poke(~pack(a));
		cmp_irq(irq, 1'b0);
		bus(1'b1, 12'h134, MSK);
		repeat (2) @(posedge sys_clk);
		cmp_irq(irq, 1'b1);
		$display("test faults and interrupt done");
		complete_run();
	end
endmodule
`default_nettype wire
